// [src/rpd_datapath.sv]
// reactive power datapath: phase shift, multiply, filter, gain, offset,
// sign and no-load detection, waveform capture and an avalon-mm slave
// assumes samples synchronous to sys_clk_in, at most one per clock
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rpd_datapath #(
   parameter int WAVE_DIV = rpd_pkg::WAVE_BASE_DIV
) (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   input  wire rpd_pkg::rpd_avmm_req_t avs_in,
   output var  rpd_pkg::rpd_avmm_rsp_t avs_out,
   input  wire rpd_pkg::rpd_sample_t  sample_in,
   output var  rpd_pkg::rpd_power_t   power_out,
   output var  logic                  irq_out
);
   typedef struct packed {
      rpd_pkg::rpd_bus_st_t bus_st;
      logic                 waitreq;
      logic [31:0]          rdata;
      logic [11:0]          gain;
      logic [15:0]          offset;
      logic [7:0]           wave_sel;
      logic [7:0]           noload_cfg;
      logic [7:0]           acc_cfg;
      logic [7:0]           ctrl;
      logic [7:0]           irq_stat;
      logic [7:0]           irq_en_l;
      logic [7:0]           irq_en_h;
      logic signed [23:0]   i_prev;
      logic signed [31:0]   integ;
      logic                 s1_v;
      logic signed [23:0]   s1_volt;
      logic signed [25:0]   s1_quad;
      logic                 s2_v;
      logic signed [31:0]   s2_prod;
      logic                 s3_v;
      logic signed [39:0]   s3_lpf;
      logic                 s4_v;
      logic signed [31:0]   s4_gain;
      logic                 s5_v;
      logic signed [31:0]   s5_pwr;
      logic                 s5_acc;
      logic                 sign_known;
      logic                 sign_neg;
      logic [12:0]          wave_div;
      logic [2:0]           wave_tick;
      logic [31:0]          wave_data;
      logic                 irq;
   } rpd_state_t;

   rpd_state_t st;
   rpd_state_t next_st;

   function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] abs32(input logic signed [31:0] x);
      return x[31] ? 32'(-x) : 32'(x);
   endfunction

   function automatic logic [31:0] nl_threshold(input logic [1:0] level);
      case (level)
         2'b01:   return rpd_pkg::NL_THR_1;
         2'b10:   return rpd_pkg::NL_THR_2;
         2'b11:   return rpd_pkg::NL_THR_3;
         default: return 32'h00000000;
      endcase
   endfunction

   logic [7:0]          idx;
   logic signed [24:0]  diff;
   logic signed [31:0]  integ_nx;
   logic signed [49:0]  prod_full;
   logic signed [40:0]  lpf_err;
   logic signed [31:0]  filt;
   logic signed [13:0]  gain_mul;
   logic signed [45:0]  gain_full;
   logic signed [40:0]  off_sum;
   logic signed [31:0]  pwr_nx;
   logic [1:0]          nl_level;
   logic                below;
   logic                now_neg;
   logic [7:0]          irq_set;
   logic [7:0]          irq_clr;
   logic [2:0]          rate_mask;
   logic                wave_emit;
   logic [31:0]         wr_word;

   always_comb begin
      next_st   = st;
      idx       = st.rdata[7:0];
      diff      = 25'sh0;
      integ_nx  = st.integ;
      prod_full = 50'sh0;
      lpf_err   = 41'sh0;
      filt      = st.s3_lpf[39:8];
      gain_mul  = 14'sh0;
      gain_full = 46'sh0;
      off_sum   = 41'sh0;
      pwr_nx    = st.s5_pwr;
      nl_level  = st.noload_cfg[rpd_pkg::NL_LEVEL_LSB +: 2];
      below     = 1'b0;
      now_neg   = 1'b0;
      irq_set   = 8'h00;
      irq_clr   = 8'h00;
      rate_mask = 3'h0;
      wave_emit = 1'b0;
      wr_word   = 32'h00000000;

      // register access: answer one cycle after the request appears
      idx = avs_in.address[9:2];
      case (st.bus_st)
         rpd_pkg::RPD_BUS_IDLE: begin
            if (avs_in.read || avs_in.write) begin
               next_st.waitreq = 1'b0;
               next_st.bus_st  = rpd_pkg::RPD_BUS_ANSWER;
               next_st.rdata   = 32'h00000000;
               if (avs_in.read) begin
                  case (idx)
                     rpd_pkg::IDX_WAVE_DATA:  next_st.rdata = st.wave_data;
                     rpd_pkg::IDX_WAVE_SEL:   next_st.rdata[7:0] = st.wave_sel;
                     rpd_pkg::IDX_NOLOAD_CFG:
                        next_st.rdata[7:0] = st.noload_cfg;
                     rpd_pkg::IDX_ACC_CFG:    next_st.rdata[7:0] = st.acc_cfg;
                     rpd_pkg::IDX_GAIN:       next_st.rdata[11:0] = st.gain;
                     rpd_pkg::IDX_OFFSET:     next_st.rdata[15:0] = st.offset;
                     rpd_pkg::IDX_IRQ_STAT_L: next_st.rdata[7:0] = st.irq_stat;
                     rpd_pkg::IDX_IRQ_EN_L:   next_st.rdata[7:0] = st.irq_en_l;
                     rpd_pkg::IDX_IRQ_EN_H:   next_st.rdata[7:0] = st.irq_en_h;
                     rpd_pkg::IDX_AVG_PWR:    next_st.rdata = st.s5_pwr;
                     rpd_pkg::IDX_DSP_CTRL:   next_st.rdata[7:0] = st.ctrl;
                     default:                 next_st.rdata = 32'h00000000;
                  endcase
               end
            end
         end
         rpd_pkg::RPD_BUS_ANSWER: begin
            // the write lands on the edge where the master sees waitrequest low
            next_st.waitreq = 1'b1;
            next_st.bus_st  = rpd_pkg::RPD_BUS_IDLE;
            if (avs_in.write) begin
               case (idx)
                  rpd_pkg::IDX_WAVE_SEL: begin
                     wr_word = be_merge({24'h0, st.wave_sel},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.wave_sel = wr_word[7:0];
                  end
                  rpd_pkg::IDX_NOLOAD_CFG: begin
                     wr_word = be_merge({24'h0, st.noload_cfg},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.noload_cfg = wr_word[7:0];
                  end
                  rpd_pkg::IDX_ACC_CFG: begin
                     wr_word = be_merge({24'h0, st.acc_cfg},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.acc_cfg = wr_word[7:0];
                  end
                  rpd_pkg::IDX_GAIN: begin
                     wr_word = be_merge({20'h0, st.gain},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.gain = wr_word[11:0];
                  end
                  rpd_pkg::IDX_OFFSET: begin
                     wr_word = be_merge({16'h0, st.offset},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.offset = wr_word[15:0];
                  end
                  rpd_pkg::IDX_IRQ_STAT_L: begin
                     if (avs_in.byteenable[0]) begin
                        irq_clr = avs_in.writedata[7:0];
                     end
                  end
                  rpd_pkg::IDX_IRQ_EN_L: begin
                     wr_word = be_merge({24'h0, st.irq_en_l},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.irq_en_l = wr_word[7:0];
                  end
                  rpd_pkg::IDX_IRQ_EN_H: begin
                     wr_word = be_merge({24'h0, st.irq_en_h},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.irq_en_h = wr_word[7:0];
                  end
                  rpd_pkg::IDX_DSP_CTRL: begin
                     wr_word = be_merge({24'h0, st.ctrl},
                                        avs_in.writedata, avs_in.byteenable);
                     next_st.ctrl = wr_word[7:0];
                  end
                  default: begin
                     wr_word = 32'h00000000;
                  end
               endcase
            end
         end
         default: begin
            next_st.waitreq = 1'b1;
            next_st.bus_st  = rpd_pkg::RPD_BUS_IDLE;
         end
      endcase

      // stage 1: quadrature current
      next_st.s1_v = sample_in.valid;
      if (sample_in.valid) begin
         next_st.s1_volt = sample_in.voltage;
         next_st.i_prev  = sample_in.current;
         diff = 25'(sample_in.current) - 25'(st.i_prev);
         integ_nx = st.integ + 32'(sample_in.current)
                    - (st.integ >>> rpd_pkg::LEAK_SHIFT);
         next_st.integ = integ_nx;
         // leaky integrator lags, first difference leads
         // lagging path negated so sign tracks the angle either way
         if (st.ctrl[rpd_pkg::CTRL_INTEG_BIT]) begin
            next_st.s1_quad = 26'(-(integ_nx >>> rpd_pkg::LEAK_SHIFT));
         end else begin
            next_st.s1_quad = 26'(diff);
         end
      end

      // stage 2: instantaneous reactive power
      next_st.s2_v = st.s1_v;
      if (st.s1_v) begin
         prod_full = 50'(st.s1_volt) * 50'(st.s1_quad);
         next_st.s2_prod = prod_full[rpd_pkg::PROD_SHIFT +: 32];
      end

      // stage 3: average; first order, same response as the active path
      next_st.s3_v = st.s2_v;
      if (st.s2_v) begin
         // low-pass, ripple at twice line rate remains
         // concatenation is unsigned: sign it before widening
         lpf_err = 41'($signed({st.s2_prod, 8'h00})) - 41'(st.s3_lpf);
         next_st.s3_lpf = st.s3_lpf + 40'(lpf_err >>> rpd_pkg::LPF_SHIFT);
      end

      // stage 4: gain
      next_st.s4_v = st.s3_v;
      if (st.s3_v) begin
         gain_mul  = 14'(rpd_pkg::GAIN_ONE) + 14'($signed(st.gain));
         gain_full = 46'(filt) * 46'(gain_mul);
         next_st.s4_gain = gain_full[rpd_pkg::GAIN_FRAC +: 32];
      end

      // stage 5: offset, then threshold on the calibrated value
      next_st.s5_v = st.s4_v;
      if (st.s4_v) begin
         // offset sits eight bits below the output lsb
         // offset after gain, before the threshold
         off_sum = 41'({st.s4_gain, 8'h00}) + 41'($signed(st.offset));
         pwr_nx  = off_sum[rpd_pkg::OFFSET_FRAC +: 32];
         next_st.s5_pwr = pwr_nx;
         below = (nl_level != 2'b00) &&
                 (abs32(pwr_nx) < nl_threshold(nl_level));
         next_st.s5_acc = !below;
         if (below) begin
            irq_set[rpd_pkg::IRQ_NOLOAD_BIT] = 1'b1;
         end
         now_neg = pwr_nx[31];
         next_st.sign_known = 1'b1;
         next_st.sign_neg   = now_neg;
         if (st.sign_known) begin
            if (!st.acc_cfg[rpd_pkg::ACC_SIGN_DIR_BIT] &&
                !st.sign_neg && now_neg) begin
               irq_set[rpd_pkg::IRQ_SIGN_BIT] = 1'b1;
            end
            if (st.acc_cfg[rpd_pkg::ACC_SIGN_DIR_BIT] &&
                st.sign_neg && !now_neg) begin
               irq_set[rpd_pkg::IRQ_SIGN_BIT] = 1'b1;
            end
         end
      end

      // waveform capture on a divided rate
      if (st.wave_div == 13'(WAVE_DIV - 1)) begin
         next_st.wave_div  = 13'h0000;
         next_st.wave_tick = st.wave_tick + 3'h1;
         // every 1, 2, 4 or 8 base ticks
         case (st.wave_sel[rpd_pkg::WSEL_RATE_LSB +: 2])
            2'b00:   rate_mask = 3'h0;
            2'b01:   rate_mask = 3'h1;
            2'b10:   rate_mask = 3'h3;
            default: rate_mask = 3'h7;
         endcase
         wave_emit = (st.wave_tick & rate_mask) == 3'h0;
      end else begin
         next_st.wave_div = st.wave_div + 13'h0001;
      end
      // needs the source code and the enable bit together
      if (wave_emit &&
          st.wave_sel[rpd_pkg::WSEL_SRC_LSB +: 3] == rpd_pkg::WSEL_REACTIVE &&
          st.irq_en_h[rpd_pkg::EN_H_WAVE_BIT]) begin
         next_st.wave_data = st.s5_pwr;
         irq_set[rpd_pkg::IRQ_WAVE_BIT] = 1'b1;
      end

      // sticky until written one; a new event beats the clear
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
      // any enabled flag holds the line
      next_st.irq = |(next_st.irq_stat & next_st.irq_en_l);
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st         <= '0;
         st.waitreq <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avs_out.readdata    = st.rdata;
   assign avs_out.waitrequest = st.waitreq;
   assign power_out.valid      = st.s5_v;
   assign power_out.accumulate = st.s5_acc;
   assign power_out.value      = st.s5_pwr;
   assign irq_out = st.irq;
endmodule
`default_nettype wire

// [src/rpd_pkg.sv]
// constants, field layouts and carrier types of the reactive power datapath
// assumes one 125 MHz clock, synchronous samples and an avalon-mm host
// What this block does
// - multiply voltage by 90-degree shifted current
// - low-pass filter product like active power
// - route samples to waveform register when enabled
// - waveform rate 25.6, 12.8, 6.4, 3.2 ksps
// - gain scales by one plus word/4096
// - signed 16-bit offset added to result
// - 256 offset counts equal one lsb
// - integrator on: -90 path negated to +90, off +90
// - average power sign follows phase angle
// - direction bit clear: positive-to-negative sets flag
// - direction bit set: negative-to-positive sets flag
// - enabled sign flag holds interrupt until cleared
// - no accumulation below no-load threshold
// - below threshold sets no-load flag
// - enabled no-load flag holds interrupt until cleared
// - level field picks threshold or disables
package rpd_pkg;
   localparam int SAMPLE_W = 24;
   localparam int PWR_W    = 32;
   localparam int IDX_W    = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_WAVE_DATA  = 8'h01;
   localparam logic [7:0] IDX_WAVE_SEL   = 8'h0d;
   localparam logic [7:0] IDX_NOLOAD_CFG = 8'h0e;
   localparam logic [7:0] IDX_ACC_CFG    = 8'h0f;
   localparam logic [7:0] IDX_GAIN       = 8'h1e;
   localparam logic [7:0] IDX_OFFSET     = 8'h21;
   localparam logic [7:0] IDX_IRQ_STAT_L = 8'h30;
   localparam logic [7:0] IDX_IRQ_EN_L   = 8'h31;
   localparam logic [7:0] IDX_IRQ_EN_H   = 8'h32;
   localparam logic [7:0] IDX_AVG_PWR    = 8'h33;
   localparam logic [7:0] IDX_DSP_CTRL   = 8'h34;
   // field positions
   localparam int IRQ_NOLOAD_BIT   = 1;
   localparam int IRQ_SIGN_BIT     = 4;
   localparam int IRQ_WAVE_BIT     = 7;
   localparam int EN_H_WAVE_BIT    = 5;
   localparam int ACC_SIGN_DIR_BIT = 5;
   localparam int NL_LEVEL_LSB     = 2;
   localparam int CTRL_INTEG_BIT   = 0;
   localparam int WSEL_SRC_LSB     = 0;
   localparam int WSEL_RATE_LSB    = 3;
   localparam logic [2:0] WSEL_REACTIVE = 3'h3;
   // arithmetic scaling
   localparam int GAIN_W      = 12;
   localparam int OFFSET_W    = 16;
   localparam int GAIN_FRAC   = 12;
   localparam int OFFSET_FRAC = 8;
   localparam int LPF_SHIFT   = 8;
   localparam int LEAK_SHIFT  = 6;
   localparam int PROD_SHIFT  = 18;
   localparam logic [13:0] GAIN_ONE = 14'h1000;
   // timing
   localparam longint CLK_HZ        = 125000000;
   localparam longint WAVE_BASE_SPS = 25600;
   localparam int WAVE_BASE_DIV     = int'(CLK_HZ / WAVE_BASE_SPS);
   localparam int WAVE_CNT_W        = 13;
   // no-load thresholds in parts per ten million of full scale
   localparam longint NL_FULL_SCALE = 64'h000000007fffffff;
   localparam longint NL_DEN        = 10000000;
   localparam longint NL_PART_1     = 1500;
   localparam longint NL_PART_2     = 750;
   localparam longint NL_PART_3     = 370;
   localparam logic [31:0] NL_THR_1 = 32'(NL_FULL_SCALE * NL_PART_1 / NL_DEN);
   localparam logic [31:0] NL_THR_2 = 32'(NL_FULL_SCALE * NL_PART_2 / NL_DEN);
   localparam logic [31:0] NL_THR_3 = 32'(NL_FULL_SCALE * NL_PART_3 / NL_DEN);

   typedef enum logic [1:0] {
      RPD_BUS_IDLE   = 2'b00,
      RPD_BUS_ANSWER = 2'b01
   } rpd_bus_st_t;

   typedef struct packed {
      logic                       valid;
      logic signed [SAMPLE_W-1:0] voltage;
      logic signed [SAMPLE_W-1:0] current;
   } rpd_sample_t;

   typedef struct packed {
      logic [9:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } rpd_avmm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } rpd_avmm_rsp_t;

   typedef struct packed {
      logic                    valid;
      logic                    accumulate;
      logic signed [PWR_W-1:0] value;
   } rpd_power_t;
endpackage

// [test/rpd_adc_model.sv]
// sine source for the voltage and current sample channels
// assumes one sample pair per clock once reset is low
`timescale 1ns/1ps
`default_nettype none
module rpd_adc_model (
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   input  wire logic [22:0]          amp_in,
   input  wire logic signed [7:0]    phase_in,
   output var  rpd_pkg::rpd_sample_t sample_out
);
   real        tbl [64];
   logic [5:0] k;
   initial begin
      sample_out = '0;
      for (int i = 0; i < 64; i++) begin
         tbl[i] = $sin(6.283185307 * i / 64.0);
      end
   end
   // voltage leads current by phase_in steps of 64 a line cycle
   always @(posedge clk_in) begin
      k <= rst_in ? 6'h00 : k + 6'h01;
      sample_out.valid   <= !rst_in;
      sample_out.voltage <= 24'($rtoi(tbl[6'(k + phase_in[5:0])] * amp_in));
      sample_out.current <= 24'($rtoi(tbl[k] * amp_in));
   end
endmodule
`default_nettype wire

// [test/rpd_datapath_sva.sv]
// port checker for the reactive power datapath
// assumes a bind from the bench top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module rpd_datapath_sva #(
   parameter int WAVE_DIV = rpd_pkg::WAVE_BASE_DIV
) (
   input wire logic                   sys_clk_in,
   input wire logic                   rst_in,
   input wire rpd_pkg::rpd_avmm_req_t avs_in,
   input wire rpd_pkg::rpd_avmm_rsp_t avs_out,
   input wire rpd_pkg::rpd_sample_t   sample_in,
   input wire rpd_pkg::rpd_power_t    power_out,
   input wire logic                   irq_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic signed [31:0] thr;
   assign thr = $signed(rpd_pkg::NL_THR_1);
   sequence req_start;
      $rose(avs_in.read || avs_in.write) && avs_out.waitrequest;
   endsequence
   sequence one_answer;
      !avs_out.waitrequest ##1 avs_out.waitrequest;
   endsequence
   AST_BUS_ANSWER: assert property (req_start |=> one_answer)
      else $error("bus answer not one cycle after request");
   AST_BUS_CAUSE: assert property (
      !avs_out.waitrequest |-> $past(avs_in.read || avs_in.write))
      else $error("bus answer without request");
   AST_RDATA_HOLD: assert property (
      avs_out.waitrequest |-> $stable(avs_out.readdata))
      else $error("read data moved between answers");
   AST_POWER_LAT: assert property (
      sample_in.valid |-> ##5 power_out.valid)
      else $error("power result missing five cycles after sample");
   AST_POWER_CAUSE: assert property (
      power_out.valid |-> $past(sample_in.valid, 5))
      else $error("power result without sample");
   AST_POWER_HOLD: assert property (!power_out.valid |->
      $stable(power_out.value) && $stable(power_out.accumulate))
      else $error("power result moved without valid");
   AST_ACC_LARGE: assert property (
      power_out.valid &&
      (power_out.value > thr || power_out.value < -thr) |->
      power_out.accumulate)
      else $error("accumulation off above every threshold");
   AST_IRQ_MASK_OFF: assert property (
      avs_in.write &&
      !avs_out.waitrequest && avs_in.byteenable[0] &&
      avs_in.address[9:2] == rpd_pkg::IDX_IRQ_EN_L &&
      avs_in.writedata[7:0] == 8'h00 |-> ##2 !irq_out)
      else $error("irq high with all enables clear");
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the reactive power datapath
// assumes the sine model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WDIV = 8;
   logic                   sys_clk_in = 1'b0;
   logic                   rst_in = 1'b1;
   rpd_pkg::rpd_avmm_req_t avs_in = '0;
   rpd_pkg::rpd_avmm_rsp_t avs_out;
   rpd_pkg::rpd_sample_t   sample;
   rpd_pkg::rpd_power_t    power_out;
   logic                   irq_out;
   logic [22:0]            amp = '0;
   logic signed [7:0]      phase = 8'sh08;
   logic [31:0]            q;
   int                     failures = 0;
   int                     num_checks = 0;
   longint                 s0;
   time                    t0;
   always #4 sys_clk_in = ~sys_clk_in;
   rpd_adc_model u_rpd_adc_model (.clk_in(sys_clk_in), .rst_in(rst_in),
      .amp_in(amp), .phase_in(phase), .sample_out(sample));
   rpd_datapath #(.WAVE_DIV(WDIV)) u_rpd_datapath (.sys_clk_in(sys_clk_in),
      .rst_in(rst_in), .avs_in(avs_in), .avs_out(avs_out),
      .sample_in(sample), .power_out(power_out), .irq_out(irq_out));
   task automatic finish_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until waitrequest low is sampled
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk_in);
      avs_in.address <= {idx, 2'b00};
      avs_in.read <= !w;
      avs_in.write <= w;
      avs_in.writedata <= d;
      avs_in.byteenable <= 4'hf;
      n = 0;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (avs_out.waitrequest !== 1'b0 && n < 100);
      if (avs_out.waitrequest !== 1'b0) begin
         failures++;
         finish_test();
      end
      q = avs_out.readdata;
      avs_in.read <= 1'b0;
      avs_in.write <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
      bus(1'b0, idx, '0);
      chk(q, e);
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq_out !== v && n < 400) begin
         @(posedge sys_clk_in);
         n++;
      end
      if (irq_out !== v) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic sum64(output longint s);
      s = 0;
      repeat (64) begin
         @(posedge sys_clk_in);
         s += longint'(power_out.value);
      end
   endtask
   // ripple averages out over one line cycle of 64 samples
   task automatic gain_chk(input logic [11:0] g);
      longint s, e, d, a;
      bus(1'b1, rpd_pkg::IDX_GAIN, {20'h0, g});
      run(10);
      sum64(s);
      e = s0 * (4096 + longint'($signed(g))) / 4096;
      d = (s > e) ? s - e : e - s;
      a = (e < 0) ? -e : e;
      chk({31'h0, d * 50 < a}, 32'h1);
   endtask
   initial begin
      run(4);
      rst_in <= 1'b0;
      rdc(rpd_pkg::IDX_GAIN, '0);
      rdc(rpd_pkg::IDX_OFFSET, '0);
      chk({31'h0, irq_out}, '0);
      bus(1'b1, rpd_pkg::IDX_GAIN, 32'hffff_f8ff);
      rdc(rpd_pkg::IDX_GAIN, 32'h0000_08ff);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h1234_8000);
      rdc(rpd_pkg::IDX_OFFSET, 32'h0000_8000);
      bus(1'b1, 8'hff, 32'hffff_ffff);
      rdc(8'hff, '0);
      bus(1'b1, rpd_pkg::IDX_GAIN, '0);
      run(10);
      chk(power_out.value, 32'hffff_ff80);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h0000_ff00);
      run(10);
      chk(power_out.value, 32'hffff_ffff);
      bus(1'b1, rpd_pkg::IDX_OFFSET, '0);
      for (int lv = 3; lv >= 0; lv--) begin
         bus(1'b1, rpd_pkg::IDX_NOLOAD_CFG, 32'(lv << 2));
         run(10);
         bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'hff);
         run(10);
         rdc(rpd_pkg::IDX_IRQ_STAT_L, (lv > 0) ? 32'h2 : 32'h0);
         chk({31'h0, power_out.accumulate}, 32'(lv == 0));
         bus(1'b1, rpd_pkg::IDX_IRQ_EN_L, 32'h2);
         run(4);
         chk({31'h0, irq_out}, 32'(lv > 0));
         bus(1'b1, rpd_pkg::IDX_IRQ_EN_L, '0);
         run(4);
         chk({31'h0, irq_out}, '0);
      end
      // large enough to clear the highest no-load threshold
      amp <= 23'h200000;
      for (int ig = 0; ig < 2; ig++) begin
         bus(1'b1, rpd_pkg::IDX_DSP_CTRL, 32'(ig));
         bus(1'b1, rpd_pkg::IDX_ACC_CFG, '0);
         phase <= 8'sh08;
         run(3000);
         chk({31'h0, power_out.value > 0}, 32'h1);
         bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'hff);
         phase <= -8'sh08;
         run(3000);
         chk({31'h0, power_out.value < 0}, 32'h1);
         bus(1'b0, rpd_pkg::IDX_IRQ_STAT_L, '0);
         chk({31'h0, q[4]}, 32'h1);
         bus(1'b1, rpd_pkg::IDX_IRQ_EN_L, 32'h10);
         run(4);
         chk({31'h0, irq_out}, 32'h1);
         bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'h10);
         run(4);
         chk({31'h0, irq_out}, '0);
         bus(1'b1, rpd_pkg::IDX_IRQ_EN_L, '0);
         bus(1'b1, rpd_pkg::IDX_ACC_CFG, 32'h20);
         phase <= 8'sh08;
         run(3000);
         bus(1'b0, rpd_pkg::IDX_IRQ_STAT_L, '0);
         chk({31'h0, q[4]}, 32'h1);
      end
      run(10);
      sum64(s0);
      gain_chk(12'h800);
      gain_chk(12'h7ff);
      amp <= '0;
      // mid-run reset also clears filter residue left by the sine run
      rst_in <= 1'b1;
      run(4);
      rst_in <= 1'b0;
      rdc(rpd_pkg::IDX_GAIN, '0);
      // silent sources and offset steps cross zero without ripple
      bus(1'b1, rpd_pkg::IDX_ACC_CFG, 32'h20);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h0000_0100);
      run(10);
      bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'hff);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h0000_ff00);
      run(10);
      bus(1'b0, rpd_pkg::IDX_IRQ_STAT_L, '0);
      chk({31'h0, q[4]}, '0);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h0000_0100);
      run(10);
      bus(1'b0, rpd_pkg::IDX_IRQ_STAT_L, '0);
      chk({31'h0, q[4]}, 32'h1);
      bus(1'b1, rpd_pkg::IDX_ACC_CFG, '0);
      bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'hff);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h0000_ff00);
      run(10);
      bus(1'b0, rpd_pkg::IDX_IRQ_STAT_L, '0);
      chk({31'h0, q[4]}, 32'h1);
      bus(1'b1, rpd_pkg::IDX_GAIN, '0);
      bus(1'b1, rpd_pkg::IDX_OFFSET, 32'h0000_0100);
      bus(1'b1, rpd_pkg::IDX_IRQ_EN_H, 32'h20);
      bus(1'b1, rpd_pkg::IDX_IRQ_EN_L, 32'h80);
      run(3000);
      for (int r = 0; r < 4; r++) begin
         bus(1'b1, rpd_pkg::IDX_WAVE_SEL, 32'((r << 3) | 3));
         bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'h80);
         wait_irq(1'b0);
         wait_irq(1'b1);
         t0 = $time;
         bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'h80);
         wait_irq(1'b0);
         wait_irq(1'b1);
         chk(32'(($time - t0) / 8), 32'(WDIV << r));
      end
      rdc(rpd_pkg::IDX_WAVE_DATA, 32'h1);
      bus(1'b1, rpd_pkg::IDX_IRQ_EN_H, '0);
      bus(1'b1, rpd_pkg::IDX_IRQ_STAT_L, 32'h80);
      run(200);
      chk({31'h0, irq_out}, '0);
      finish_test();
   end
endmodule
bind rpd_datapath rpd_datapath_sva #(.WAVE_DIV(WAVE_DIV)) u_rpd_datapath_sva (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_in(avs_in),
   .avs_out(avs_out), .sample_in(sample_in), .power_out(power_out),
   .irq_out(irq_out));
`default_nettype wire
